// ### design/can_flag_abort_filter_regs.sv
// register file for can receive/transmit flags, aborts and acceptance control
//
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/1ps
module can_flag_abort_filter_regs
    import can_flag_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         wb_cyc_i,
    input  wire logic         wb_stb_i,
    input  wire logic         wb_we_i,
    input  wire logic [5:0]   wb_adr_i,
    input  wire logic [3:0]   wb_sel_i,
    input  wire logic [31:0]  wb_dat_i,
    output logic      [31:0]  wb_dat_o,
    output logic              wb_ack_o,
    input  wire rx_event_s    rx_event_i,
    input  wire rx_cond_s     rx_cond_i,
    input  wire tx_event_s    tx_event_i,
    input  wire logic [7:0]   rx_err_count_i,
    input  wire logic [7:0]   tx_err_count_i,
    input  wire logic         sleep_i,
    output logic              fg_load_o,
    output logic [1:0]        accept_mode_o,
    output logic [NUM_TXB-1:0] abort_request_o,
    output logic              wakeup_irq_o,
    output logic              error_irq_o,
    output logic              receive_irq_o,
    output logic              transmit_irq_o
);

    logic [7:0]          receive_status_flags;
    logic [7:0]          receive_interrupt_enables;
    logic [NUM_TXB-1:0]  transmit_empty_flag;
    logic [NUM_TXB-1:0]  abort_acknowledge;
    logic [NUM_TXB-1:0]  abort_request;
    logic [NUM_TXB-1:0]  transmit_empty_irq_enable;
    logic [1:0]          acceptance_mode;
    logic [1:0]          filter_hit_indicator;
    logic                soft_reset_control;
    logic                wr_req;
    logic                rd_req;
    logic                lane0;
    logic                accept_ok;
    logic [7:0]          hold_cond;
    logic [NUM_TXB-1:0]  grant_abort;
    logic [NUM_TXB-1:0]  set_empty;
    logic [7:0]          next_rd;

    function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
        return a == o;
    endfunction : hit

    // one access per request: ack goes low the cycle after it was given
    assign wr_req = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
    assign rd_req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
    assign lane0  = wb_sel_i[0];

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end

    // module control zero: soft reset bit, set after hard reset
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            soft_reset_control <= RST_SOFT_RESET_CONTROL;
        else if (wr_req && lane0 && hit(wb_adr_i, OFS_MCR0))
            soft_reset_control <= wb_dat_i[B_SOFT_RESET_CONTROL];
    end

    // closed filter or unread foreground blocks the copy
    assign accept_ok = rx_event_i.rx_accept
                     && acceptance_mode != MODE_SHUT
                     && !receive_status_flags[B_RXF]
                     && !soft_reset_control;

    // flags still backed by a live condition refuse the clear
    always_comb
    begin
        hold_cond         = 8'h00;
        hold_cond[B_RWRN] = rx_cond_i.rx_warn;
        hold_cond[B_TWRN] = rx_cond_i.tx_warn;
        hold_cond[B_RERR] = rx_cond_i.rx_passive;
        hold_cond[B_TERR] = rx_cond_i.tx_passive;
        hold_cond[B_BOFF] = rx_cond_i.busoff;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || soft_reset_control)
            receive_status_flags <= RST_RFLG;
        else
        begin
            if (wr_req && lane0 && hit(wb_adr_i, {2'h0, OFS_RFLG}))
                receive_status_flags <= receive_status_flags
                    & ~(wb_dat_i[7:0] & ~hold_cond);
            // set wins over a simultaneous clear
            if (rx_event_i.wakeup)
                receive_status_flags[B_WUP] <= 1'b1;
            if (rx_event_i.rx_warn)
                receive_status_flags[B_RWRN] <= 1'b1;
            if (rx_event_i.tx_warn)
                receive_status_flags[B_TWRN] <= 1'b1;
            if (rx_event_i.rx_passive)
                receive_status_flags[B_RERR] <= 1'b1;
            if (rx_event_i.tx_passive)
                receive_status_flags[B_TERR] <= 1'b1;
            if (rx_event_i.busoff)
                receive_status_flags[B_BOFF] <= 1'b1;
            if (rx_event_i.overrun)
                receive_status_flags[B_OVR] <= 1'b1;
            if (accept_ok)
                receive_status_flags[B_RXF] <= 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i || soft_reset_control)
            receive_interrupt_enables <= RST_RIER;
        else if (wr_req && lane0 && hit(wb_adr_i, {2'h0, OFS_RIER}))
            receive_interrupt_enables <= wb_dat_i[7:0];
    end

    // hit number follows the message copied to the foreground
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            filter_hit_indicator <= 2'h0;
        else if (accept_ok)
            filter_hit_indicator <= rx_event_i.rx_hit;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            acceptance_mode <= MODE_32;
        else if (wr_req && lane0 && soft_reset_control
                 && hit(wb_adr_i, OFS_IDAC))
            acceptance_mode <= wb_dat_i[B_IDAM +: 2];
    end

    // per-buffer transmit handshake
    genvar gi;
    generate
        for (gi = 0; gi < NUM_TXB; gi++)
        begin : g_txb
            // abort allowed before start or after a failed attempt
            assign grant_abort[gi] = abort_request[gi]
                && !transmit_empty_flag[gi]
                && (!tx_event_i.started[gi] || tx_event_i.failed[gi]);
            assign set_empty[gi] = !transmit_empty_flag[gi]
                && (tx_event_i.sent[gi] || grant_abort[gi]);

            always_ff @(posedge clk_i)
            begin
                if (rst_i || soft_reset_control)
                begin
                    transmit_empty_flag[gi] <= RST_TXE[gi];
                    abort_acknowledge[gi]   <= 1'b0;
                end
                else if (set_empty[gi])
                begin
                    transmit_empty_flag[gi] <= 1'b1;
                    abort_acknowledge[gi]   <= !tx_event_i.sent[gi];
                end
                else if (wr_req && lane0
                         && hit(wb_adr_i, {2'h0, OFS_TFLG})
                         && wb_dat_i[B_TXE + gi])
                begin
                    transmit_empty_flag[gi] <= 1'b0;
                    abort_acknowledge[gi]   <= 1'b0;
                end
            end

            always_ff @(posedge clk_i)
            begin
                if (rst_i || soft_reset_control)
                    abort_request[gi] <= RST_TCTL[B_ABTRQ + gi];
                else if (set_empty[gi])
                    abort_request[gi] <= 1'b0;
                else if (wr_req && lane0
                         && hit(wb_adr_i, {2'h0, OFS_TCTL})
                         && wb_dat_i[B_ABTRQ + gi])
                    abort_request[gi] <= 1'b1;
            end

            always_ff @(posedge clk_i)
            begin
                if (rst_i || soft_reset_control)
                    transmit_empty_irq_enable[gi] <= RST_TCTL[B_TXEIE + gi];
                else if (wr_req && lane0
                         && hit(wb_adr_i, {2'h0, OFS_TCTL}))
                    transmit_empty_irq_enable[gi] <= wb_dat_i[B_TXEIE + gi];
            end
        end
    endgenerate

    // read mux; counters read zero outside sleep or soft reset
    always_comb
    begin
        next_rd = 8'h00;
        case (wb_adr_i)
            {2'h0, OFS_RFLG}: next_rd = receive_status_flags;
            {2'h0, OFS_RIER}: next_rd = receive_interrupt_enables;
            {2'h0, OFS_TFLG}: next_rd = {1'b0, abort_acknowledge,
                                         1'b0, transmit_empty_flag};
            {2'h0, OFS_TCTL}: next_rd = {1'b0, abort_request,
                                         1'b0, transmit_empty_irq_enable};
            OFS_IDAC: next_rd = {2'h0, acceptance_mode,
                                 2'h0, filter_hit_indicator};
            OFS_RXER: next_rd = (sleep_i || soft_reset_control)
                                ? rx_err_count_i : 8'h00;
            OFS_TXER: next_rd = (sleep_i || soft_reset_control)
                                ? tx_err_count_i : 8'h00;
            OFS_MCR0: next_rd = {7'h00, soft_reset_control};
            default:  next_rd = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= 32'h0000_0000;
        else if (rd_req)
            wb_dat_o <= {24'h00_0000, next_rd};
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fg_load_o       <= 1'b0;
            accept_mode_o   <= MODE_32;
            abort_request_o <= '0;
        end
        else
        begin
            fg_load_o       <= accept_ok;
            accept_mode_o   <= acceptance_mode;
            abort_request_o <= abort_request;
        end
    end

    // interrupt lines: AND each flag with its enable, OR by class
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wakeup_irq_o   <= 1'b0;
            error_irq_o    <= 1'b0;
            receive_irq_o  <= 1'b0;
            transmit_irq_o <= 1'b0;
        end
        else
        begin
            wakeup_irq_o   <= receive_status_flags[B_WUP]
                            & receive_interrupt_enables[B_WUP];
            error_irq_o    <= |(receive_status_flags[B_RWRN:B_OVR]
                & receive_interrupt_enables[B_RWRN:B_OVR]);
            receive_irq_o  <= receive_status_flags[B_RXF]
                            & receive_interrupt_enables[B_RXF];
            transmit_irq_o <= |(transmit_empty_flag
                            & transmit_empty_irq_enable);
        end
    end

    // assertions
    property p_rxf_blocks_load;
        @(posedge clk_i) disable iff (rst_i)
        receive_status_flags[B_RXF] |=> !fg_load_o;
    endproperty
    a_rxf_blocks_load: assert property (p_rxf_blocks_load)
        else $error("foreground loaded while full");

    property p_closed_no_load;
        @(posedge clk_i) disable iff (rst_i)
        acceptance_mode == MODE_SHUT |=> !fg_load_o;
    endproperty
    a_closed_no_load: assert property (p_closed_no_load)
        else $error("load in closed filter mode");

    property p_soft_reset_holds;
        @(posedge clk_i) disable iff (rst_i)
        soft_reset_control |=> receive_status_flags == RST_RFLG
            && transmit_empty_flag == RST_TXE && abort_request == '0;
    endproperty
    a_soft_reset_holds: assert property (p_soft_reset_holds)
        else $error("register not held under soft reset");

    property p_overrun_irq;
        @(posedge clk_i) disable iff (rst_i || soft_reset_control)
        rx_event_i.overrun && receive_interrupt_enables[B_OVR]
            |=> ##1 error_irq_o;
    endproperty
    a_overrun_irq: assert property (p_overrun_irq)
        else $error("overrun did not raise error interrupt");

    sequence s_empty_rises(int i);
        !transmit_empty_flag[i] ##1 transmit_empty_flag[i];
    endsequence
    property p_empty_clears_req;
        @(posedge clk_i) disable iff (rst_i)
        s_empty_rises(0) |-> !abort_request[0];
    endproperty
    a_empty_clears_req: assert property (p_empty_clears_req)
        else $error("abort request survived empty");

    property p_ack_with_empty;
        @(posedge clk_i) disable iff (rst_i)
        abort_acknowledge[1] |-> transmit_empty_flag[1];
    endproperty
    a_ack_with_empty: assert property (p_ack_with_empty)
        else $error("acknowledge set without empty");

    property p_idac_locked;
        @(posedge clk_i) disable iff (rst_i)
        !soft_reset_control |=> $stable(acceptance_mode);
    endproperty
    a_idac_locked: assert property (p_idac_locked)
        else $error("acceptance mode changed outside soft reset");

    property p_rx_irq;
        @(posedge clk_i) disable iff (rst_i)
        receive_irq_o |-> $past(receive_status_flags[B_RXF])
            && $past(receive_interrupt_enables[B_RXF]);
    endproperty
    a_rx_irq: assert property (p_rx_irq)
        else $error("receive interrupt without flag and enable");

    // a sent buffer must read back as sent, not aborted
    property p_sent_sets_empty;
        @(posedge clk_i) disable iff (rst_i || soft_reset_control)
        tx_event_i.sent[2] && !transmit_empty_flag[2]
            |=> transmit_empty_flag[2] && !abort_acknowledge[2];
    endproperty
    a_sent_sets_empty: assert property (p_sent_sets_empty)
        else $error("sent buffer not flagged empty");

    // failed attempt with a pending request must end as aborted
    property p_abort_grant;
        @(posedge clk_i) disable iff (rst_i || soft_reset_control)
        abort_request[1] && !transmit_empty_flag[1] && !tx_event_i.sent[1]
            && tx_event_i.started[1] && tx_event_i.failed[1]
            |=> transmit_empty_flag[1] && abort_acknowledge[1];
    endproperty
    a_abort_grant: assert property (p_abort_grant)
        else $error("abort of failed buffer not granted");

endmodule : can_flag_abort_filter_regs

// ### design/can_flag_pkg.sv
// constants, register map and carrier types of the can flag/abort/filter block
package can_flag_pkg;

    localparam int          ADDR_W      = 4;
    localparam int          NUM_TXB     = 3;
    // word offsets of the registers (byte address = offset)
    localparam logic [ADDR_W-1:0] OFS_RFLG = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_RIER = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_TFLG = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_TCTL = 4'hC;
    localparam logic [5:0]  OFS_IDAC    = 6'h10;
    localparam logic [5:0]  OFS_RXER    = 6'h14;
    localparam logic [5:0]  OFS_TXER    = 6'h18;
    localparam logic [5:0]  OFS_MCR0    = 6'h1C;

    // receive flag / enable bit positions (shared layout)
    localparam int          B_WUP       = 7;
    localparam int          B_RWRN      = 6;
    localparam int          B_TWRN      = 5;
    localparam int          B_RERR      = 4;
    localparam int          B_TERR      = 3;
    localparam int          B_BOFF      = 2;
    localparam int          B_OVR       = 1;
    localparam int          B_RXF       = 0;
    // transmit flags: acknowledge bits 6:4, empty bits 2:0
    localparam int          B_ABTAK     = 4;
    localparam int          B_TXE       = 0;
    // transmit control: abort request 6:4, empty enables 2:0
    localparam int          B_ABTRQ     = 4;
    localparam int          B_TXEIE     = 0;
    // acceptance control: mode 5:4, hit 1:0
    localparam int          B_IDAM      = 4;
    localparam int          B_IDHIT     = 0;
    localparam int          B_SOFT_RESET_CONTROL    = 0;

    localparam logic [7:0]  RST_RFLG    = 8'h00;
    localparam logic [7:0]  RST_RIER    = 8'h00;
    localparam logic [2:0]  RST_TXE     = 3'h7;
    localparam logic [7:0]  RST_TCTL    = 8'h00;
    localparam logic        RST_SOFT_RESET_CONTROL  = 1'b1;

    typedef enum logic [1:0] {
        MODE_32   = 2'h0,
        MODE_16   = 2'h1,
        MODE_8    = 2'h2,
        MODE_SHUT = 2'h3
    } accept_mode_e;

    // status events from the protocol engine, all one-cycle pulses
    typedef struct packed {
        logic       wakeup;
        logic       rx_warn;
        logic       tx_warn;
        logic       rx_passive;
        logic       tx_passive;
        logic       busoff;
        logic       overrun;
        logic       rx_accept;
        logic [1:0] rx_hit;
    } rx_event_s;

    // levels that keep a receive flag from being cleared
    typedef struct packed {
        logic       rx_warn;
        logic       tx_warn;
        logic       rx_passive;
        logic       tx_passive;
        logic       busoff;
    } rx_cond_s;

    typedef struct packed {
        logic [NUM_TXB-1:0] sent;
        logic [NUM_TXB-1:0] started;
        logic [NUM_TXB-1:0] failed;
    } tx_event_s;

endpackage : can_flag_pkg

// ### testbench/can_engine_model.sv
// behavioural protocol engine standing on the bus side of the block
`timescale 1ns/1ps
module can_engine_model
    import can_flag_pkg::*;
(
    input  wire logic  clk_i,
    output rx_event_s  rx_event_o,
    output rx_cond_s   rx_cond_o,
    output tx_event_s  tx_event_o,
    output logic [7:0] rx_err_count_o,
    output logic [7:0] tx_err_count_o,
    output logic       sleep_o
);
    initial
    begin
        rx_event_o = '0;
        rx_cond_o = '0;
        tx_event_o = '0;
        rx_err_count_o = 8'h00;
        tx_err_count_o = 8'h00;
        sleep_o = 1'b0;
    end

    // events last one cycle; hit only rides with an accept
    task pulse_rx(input rx_event_s e);
        @(posedge clk_i);
        rx_event_o <= e;
        @(posedge clk_i);
        rx_event_o <= '0;
    endtask : pulse_rx

    task pulse_sent(input logic [2:0] m);
        @(posedge clk_i);
        tx_event_o.sent <= m;
        @(posedge clk_i);
        tx_event_o.sent <= 3'h0;
    endtask : pulse_sent

    task set_levels(input rx_cond_s c, input logic [2:0] st,
                    input logic [2:0] fl, input logic s);
        @(posedge clk_i);
        rx_cond_o <= c;
        tx_event_o.started <= st;
        tx_event_o.failed <= fl;
        sleep_o <= s;
    endtask : set_levels

    // counters only meaningful to software in sleep or soft reset
    task set_counts(input logic [7:0] r, input logic [7:0] t);
        @(posedge clk_i);
        rx_err_count_o <= r;
        tx_err_count_o <= t;
    endtask : set_counts
endmodule : can_engine_model

// ### testbench/tb_can_flag_abort_filter_regs.sv
// self-checking bench for the can flag, abort and filter register block
`timescale 1ns/1ps
module tb_can_flag_abort_filter_regs
    import can_flag_pkg::*;
;
    localparam logic [5:0] A_RF = 6'(OFS_RFLG);
    localparam logic [5:0] A_RI = 6'(OFS_RIER);
    localparam logic [5:0] A_TF = 6'(OFS_TFLG);
    localparam logic [5:0] A_TC = 6'(OFS_TCTL);
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [5:0]  adr = 6'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat, q;
    logic        ack, fg_load, w_irq, e_irq, r_irq, t_irq;
    logic [1:0]  amode, m_mode, m_hit, h;
    logic [2:0]  arq, m_txe, m_ak, m_rq, m_tie;
    logic [7:0]  rxc, txc, m_rflg, m_rier, rc, tc;
    logic        slp;
    rx_event_s   ev;
    rx_cond_s    cnd;
    tx_event_s   tev;
    int          failures = 0;
    int          comparisons = 0;
    int          loads = 0;
    int          ld;

    can_flag_abort_filter_regs DUT (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .rx_event_i(ev), .rx_cond_i(cnd), .tx_event_i(tev),
        .rx_err_count_i(rxc), .tx_err_count_i(txc), .sleep_i(slp),
        .fg_load_o(fg_load), .accept_mode_o(amode),
        .abort_request_o(arq), .wakeup_irq_o(w_irq), .error_irq_o(e_irq),
        .receive_irq_o(r_irq), .transmit_irq_o(t_irq));

    can_engine_model ENG (.clk_i(clk_i), .rx_event_o(ev), .rx_cond_o(cnd),
        .tx_event_o(tev), .rx_err_count_o(rxc), .tx_err_count_o(txc),
        .sleep_o(slp));

    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end

    always @(posedge clk_i)
        if (fg_load === 1'b1)
            loads <= loads + 1;

    task results;
        if (failures == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: seen %0h expected %0h",
                     $time, seen, exp);
        end
    endtask : chk

    // request held until ack is sampled; cyc drops for a cycle after
    task wb(input logic w, input logic [5:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        dat <= {24'h0, d};
        do
        begin
            @(posedge clk_i);
            n++;
            if (n > 20)
            begin
                failures++;
                results();
            end
        end
        while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task rd_chk(input logic [5:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk(q, {24'h0, e});
    endtask : rd_chk

    task rd_all;
        rd_chk(A_RF, m_rflg);
        rd_chk(A_RI, m_rier);
        rd_chk(A_TF, {1'b0, m_ak, 1'b0, m_txe});
        rd_chk(A_TC, {1'b0, m_rq, 1'b0, m_tie});
        rd_chk(OFS_IDAC, {2'h0, m_mode, 2'h0, m_hit});
        chk({28'h0, w_irq, e_irq, r_irq, t_irq},
            {28'h0, m_rflg[7] & m_rier[7], |(m_rflg[6:1] & m_rier[6:1]),
            m_rflg[0] & m_rier[0], |(m_txe & m_tie)});
    endtask : rd_all

    initial
    begin
        void'($urandom(72342));
        {m_rflg, m_rier, m_ak, m_rq, m_tie, m_hit, m_mode} = '0;
        m_txe = 3'h7;
        rc = 8'($urandom);
        tc = 8'($urandom);
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        ENG.set_counts(rc, tc);
        rd_all();
        rd_chk(OFS_MCR0, 8'h01);
        rd_chk(OFS_RXER, rc);
        rd_chk(OFS_TXER, tc);
        rd_chk(6'h20, 8'h00);
        wb(1'b1, A_RI, 8'hFF);
        wb(1'b1, A_TC, 8'h77);
        wb(1'b1, A_TF, 8'h07);
        ENG.pulse_rx(10'h3FF);
        rd_all();
        for (int i = 3; i >= 0; i--)
        begin
            wb(1'b1, OFS_IDAC, 8'(i << 4));
            m_mode = 2'(i);
            rd_chk(OFS_IDAC, {2'h0, m_mode, 4'h0});
            chk({30'h0, amode}, {30'h0, m_mode});
        end
        wb(1'b1, OFS_MCR0, 8'h00);
        wb(1'b1, OFS_IDAC, 8'h30);
        rd_chk(OFS_IDAC, 8'h00);
        rd_chk(OFS_RXER, 8'h00);
        ENG.set_levels(5'h0, 3'h0, 3'h0, 1'b1);
        rd_chk(OFS_RXER, rc);
        rd_chk(OFS_TXER, tc);
        ENG.set_levels(5'h0, 3'h0, 3'h0, 1'b0);
        for (int p = 0; p < 2; p++)
        begin
            m_rier = (p == 0) ? 8'($urandom) : ~m_rier;
            wb(1'b1, A_RI, m_rier);
            for (int b = 7; b > 0; b--)
            begin
                ENG.pulse_rx(10'(1) << (b + 2));
                m_rflg[b] = 1'b1;
                rd_all();
                if (b > 1 && b < 7)
                begin
                    ENG.set_levels(5'(1) << (b - 2), 3'h0, 3'h0, 1'b0);
                    wb(1'b1, A_RF, 8'(1) << b);
                    rd_chk(A_RF, m_rflg);
                    ENG.set_levels(5'h0, 3'h0, 3'h0, 1'b0);
                end
                wb(1'b1, A_RF, 8'(1) << b);
                m_rflg[b] = 1'b0;
                rd_all();
            end
        end
        m_rier = 8'h01;
        wb(1'b1, A_RI, m_rier);
        h = 2'($urandom);
        ld = loads;
        ENG.pulse_rx({8'h01, h});
        m_rflg[0] = 1'b1;
        m_hit = h;
        rd_all();
        chk(32'(loads), 32'(ld + 1));
        ENG.pulse_rx({8'h01, ~h});
        rd_all();
        chk(32'(loads), 32'(ld + 1));
        wb(1'b1, A_RF, 8'h01); // buffer released after reading
        m_rflg[0] = 1'b0;
        ENG.pulse_rx({8'h01, ~h});
        m_rflg[0] = 1'b1;
        m_hit = ~h;
        rd_all();
        chk(32'(loads), 32'(ld + 2));
        m_tie = 3'($urandom);
        wb(1'b1, A_TC, {5'h0, m_tie});
        wb(1'b1, A_TF, 8'h70);
        rd_all();
        wb(1'b1, A_TF, 8'h07); // scheduled once loaded
        m_txe = 3'h0;
        rd_all();
        ENG.pulse_sent(3'h4);
        m_txe[2] = 1'b1;
        rd_all();
        wb(1'b1, A_TC, {4'h1, 1'b0, m_tie}); // separate from clear
        m_txe[0] = 1'b1;
        m_ak[0] = 1'b1;
        rd_all();
        ENG.set_levels(5'h0, 3'h2, 3'h0, 1'b0);
        wb(1'b1, A_TC, {4'h2, 1'b0, m_tie});
        m_rq[1] = 1'b1;
        wb(1'b1, A_TC, {4'h0, 1'b0, m_tie});
        rd_all();
        chk({29'h0, arq}, {29'h0, m_rq});
        ENG.set_levels(5'h0, 3'h2, 3'h2, 1'b0);
        m_rq[1] = 1'b0;
        m_txe[1] = 1'b1;
        m_ak[1] = 1'b1;
        rd_all();
        wb(1'b1, A_TF, 8'h01);
        m_txe[0] = 1'b0;
        m_ak[0] = 1'b0;
        rd_all();
        wb(1'b1, OFS_MCR0, 8'h01);
        {m_rflg, m_rier, m_ak, m_rq, m_tie} = '0;
        m_txe = 3'h7;
        rd_all();
        wb(1'b1, OFS_IDAC, 8'h30);
        m_mode = 2'h3;
        wb(1'b1, OFS_MCR0, 8'h00);
        ld = loads;
        ENG.pulse_rx({8'h01, 2'h2});
        rd_all();
        chk(32'(loads), 32'(ld));
        results();
    end
endmodule : tb_can_flag_abort_filter_regs
